// *** hw/tbse_map.vh ***
// Register offsets, field positions, reset values and encodings for the time base.
`ifndef TBSE_MAP_VH
`define TBSE_MAP_VH

// Register byte offsets on the APB port.
`define TBSE_OFF_CTRL     12'h000
`define TBSE_OFF_STATUS   12'h004
`define TBSE_OFF_PHASE    12'h008
`define TBSE_OFF_COUNT    12'h00c
`define TBSE_OFF_PERIOD   12'h010
`define TBSE_OFF_COMPARE_B_VALUE     12'h014
`define TBSE_OFF_INTSTAT  12'h018
`define TBSE_OFF_INTMASK  12'h01c

// Control register fields.
`define TBSE_CTL_MODE_LO   0
`define TBSE_CTL_MODE_HI   1
`define TBSE_CTL_PHASE_LOAD_ENABLE     2
`define TBSE_CTL_PRDIMM    3
`define TBSE_CTL_SOSEL_LO  4
`define TBSE_CTL_SOSEL_HI  5
`define TBSE_CTL_SWSYNC    6
`define TBSE_CTL_DIV_LO    8
`define TBSE_CTL_DIV_HI    15
`define TBSE_CTL_WIDTH     16
`define TBSE_CTL_RESET     16'h0000

// Counter modes.
`define TBSE_MODE_UPDOWN  2'h0
`define TBSE_MODE_UP      2'h1
`define TBSE_MODE_DOWN    2'h2
`define TBSE_MODE_STOP    2'h3

// Sync output sources.
`define TBSE_SO_SYNCIN    2'h0
`define TBSE_SO_ZERO      2'h1
`define TBSE_SO_COMPARE_B_VALUE      2'h2
`define TBSE_SO_OFF       2'h3

// Status and interrupt bit positions.
`define TBSE_ST_DIR       0
`define TBSE_ST_MAX       1
`define TBSE_IRQ_PRD      0
`define TBSE_IRQ_ZERO     1
`define TBSE_IRQ_COMPARE_B_VALUE     2
`define TBSE_IRQ_SYNC     3
`define TBSE_IRQ_WIDTH    4

// Counter constants.
`define TBSE_CNT_ZERO     16'h0000
`define TBSE_CNT_MAX      16'hffff
`define TBSE_PERIOD_RST   16'hffff
`define TBSE_DIV_RESET    8'h00

`endif

// *** hw/tbse_prescale.v ***
// Divider that turns the system clock into one-cycle time-base enables.
`timescale 1ns/1ns
module tbse_prescale (
  input  wire       clock,     // system clock
  input  wire       nrst,      // async reset, active low
  input  wire [7:0] divide,    // enable every divide+1 cycles
  output reg        tick       // one-cycle time-base enable
);
`include "tbse_map.vh"

  reg [7:0] count;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= `TBSE_DIV_RESET;
      tick  <= 1'b0;
    end else if (count >= divide) begin
      count <= `TBSE_DIV_RESET;
      tick  <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end

endmodule

// *** hw/tbse_timebase.v ***
// Time-base counter with event flags, sync chain and APB registers.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module tbse_timebase (
  input  wire        clock,            // system clock, 50 MHz
  input  wire        nrst,             // async reset, active low
  input  wire        psel,             // APB select
  input  wire        penable,          // APB access phase
  input  wire        pwrite,           // APB write
  input  wire [11:0] paddr,            // APB byte address
  input  wire [31:0] pwdata,           // APB write data
  output wire        pready,           // APB ready, always high
  output reg  [31:0] prdata,           // APB read data
  output wire        pslverr,          // APB error on unmapped address
  input  wire        chainSyncIn,      // sync pulse from upstream or pin
  output reg         chainSyncOut,     // sync pulse downstream
  output reg  [15:0] timebaseCounter,  // counter value
  output reg         countAtPeriod,    // counter equals active period
  output reg         countAtZero,      // counter equals zero
  output reg         countMatchCompareB, // counter equals compare B
  output reg         countDirection,   // high while counting up
  output reg         countAtMaximum,   // counter equals all ones
  output wire        timebaseClock,    // one-cycle time-base enable
  output wire        irq               // level interrupt
);
`include "tbse_map.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Registers and pin synchroniser.

  reg  [15:0] control;
  reg  [15:0] phaseValue;
  reg  [15:0] periodActive;
  reg  [15:0] periodShadow;
  reg  [15:0] compareBValue;
  reg  [3:0]  intStatus;
  reg  [3:0]  intMask;
  reg         syncMeta;
  reg         syncSync;
  reg         syncLast;
  reg         syncPending;
  reg         swSync;

  wire [1:0] countMode   = control[`TBSE_CTL_MODE_HI:`TBSE_CTL_MODE_LO];
  wire [1:0] syncOutSel  = control[`TBSE_CTL_SOSEL_HI:`TBSE_CTL_SOSEL_LO];
  wire       phaseLoadEnable     = control[`TBSE_CTL_PHASE_LOAD_ENABLE];
  wire       periodImmediateLoad = control[`TBSE_CTL_PRDIMM];
  wire [7:0] clockDivide = control[`TBSE_CTL_DIV_HI:`TBSE_CTL_DIV_LO];

  // Bus decode; the slave answers in the access cycle with no wait states.
  // Count and status are read-only; a write to them is dropped quietly.
  wire access   = psel & penable;
  wire writeHit = access & pwrite;
  wire mapped   = (paddr == `TBSE_OFF_CTRL)    |
                  (paddr == `TBSE_OFF_STATUS)  |
                  (paddr == `TBSE_OFF_PHASE)   |
                  (paddr == `TBSE_OFF_COUNT)   |
                  (paddr == `TBSE_OFF_PERIOD)  |
                  (paddr == `TBSE_OFF_COMPARE_B_VALUE)    |
                  (paddr == `TBSE_OFF_INTSTAT) |
                  (paddr == `TBSE_OFF_INTMASK);

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  tbse_prescale prescaler (
    .clock  (clock),
    .nrst   (nrst),
    .divide (clockDivide),
    .tick   (timebaseClock)
  );

  // The pin may come from another device, so it is double flopped before
  // any edge detection looks at it.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncMeta <= 1'b0;
      syncSync <= 1'b0;
      syncLast <= 1'b0;
    end else begin
      syncMeta <= chainSyncIn;
      syncSync <= syncMeta;
      syncLast <= syncSync;
    end
  end

  wire syncEdge = syncSync & ~syncLast;

  ////////////////////////////////////////////////////////////////////////////
  // Software register writes.

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      control       <= `TBSE_CTL_RESET;
      phaseValue    <= `TBSE_CNT_ZERO;
      periodShadow  <= `TBSE_PERIOD_RST;
      compareBValue <= `TBSE_CNT_ZERO;
      intMask       <= 4'h0;
      swSync        <= 1'b0;
    end else begin
      if (timebaseClock)
        swSync <= 1'b0;
      if (writeHit) begin
        case (paddr)
          `TBSE_OFF_CTRL: begin
            // The software sync bit is a strobe and never stored.
            control <= pwdata[15:0] & ~(16'h0001 << `TBSE_CTL_SWSYNC);
            if (pwdata[`TBSE_CTL_SWSYNC])
              swSync <= 1'b1;
          end
          `TBSE_OFF_PHASE:   phaseValue    <= pwdata[15:0];
          `TBSE_OFF_PERIOD: begin
            // Writes land in the shadow unless immediate load is set.
            if (!periodImmediateLoad)
              periodShadow <= pwdata[15:0];
          end
          `TBSE_OFF_COMPARE_B_VALUE:    compareBValue <= pwdata[15:0];
          `TBSE_OFF_INTMASK: intMask       <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter.

  // Sync events arriving between ticks are held until the next tick. They
  // are held whether or not phase loading is on, because a slow divider
  // would otherwise lose an edge that only has to be forwarded.
  wire syncAccepted = syncPending | syncEdge | swSync;
  wire periodWrite  = writeHit & (paddr == `TBSE_OFF_PERIOD);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timebaseCounter <= `TBSE_CNT_ZERO;
      countDirection  <= 1'b1;
      periodActive    <= `TBSE_PERIOD_RST;
      syncPending     <= 1'b0;
    end else begin
      if (timebaseClock)
        syncPending <= 1'b0;
      else if (syncEdge)
        syncPending <= 1'b1;
      if (periodWrite & periodImmediateLoad)
        periodActive <= pwdata[15:0];
      else if (timebaseClock & ~periodImmediateLoad &
               (timebaseCounter == `TBSE_CNT_ZERO))
        periodActive <= periodShadow;
      // A phase load keeps the present direction, so up-down mode resumes
      // the way it was heading.
      if (timebaseClock) begin
        if (phaseLoadEnable & syncAccepted)
          timebaseCounter <= phaseValue;
        else begin
          case (countMode)
            `TBSE_MODE_UPDOWN: begin
              if (countDirection) begin
                if (timebaseCounter >= periodActive) begin
                  countDirection  <= 1'b0;
                  timebaseCounter <= timebaseCounter - 16'h0001;
                end else
                  timebaseCounter <= timebaseCounter + 16'h0001;
              end else begin
                if (timebaseCounter == `TBSE_CNT_ZERO) begin
                  countDirection  <= 1'b1;
                  timebaseCounter <= timebaseCounter + 16'h0001;
                end else
                  timebaseCounter <= timebaseCounter - 16'h0001;
              end
            end
            `TBSE_MODE_UP: begin
              countDirection <= 1'b1;
              if (timebaseCounter >= periodActive)
                timebaseCounter <= `TBSE_CNT_ZERO;
              else
                timebaseCounter <= timebaseCounter + 16'h0001;
            end
            `TBSE_MODE_DOWN: begin
              countDirection <= 1'b0;
              if (timebaseCounter == `TBSE_CNT_ZERO)
                timebaseCounter <= periodActive;
              else
                timebaseCounter <= timebaseCounter - 16'h0001;
            end
            default: ;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event outputs and sync out.

  // The flags are registered and so trail the counter by one system clock.
  wire eqPeriod = (timebaseCounter == periodActive);
  wire eqZero   = (timebaseCounter == `TBSE_CNT_ZERO);
  wire eqCmpB   = (timebaseCounter == compareBValue);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      countAtPeriod      <= 1'b0;
      countAtZero        <= 1'b0;
      countMatchCompareB <= 1'b0;
      countAtMaximum     <= 1'b0;
    end else begin
      countAtPeriod      <= eqPeriod;
      countAtZero        <= eqZero;
      countMatchCompareB <= eqCmpB;
      countAtMaximum <= (timebaseCounter == `TBSE_CNT_MAX);
    end
  end

  // The output pulse is one tick long: it rises with a tick and falls at
  // the next, so downstream modules on the same divider see it once.
  reg next_syncOut;
  always @* begin
    case (syncOutSel)
      `TBSE_SO_SYNCIN: next_syncOut = syncAccepted;
      `TBSE_SO_ZERO:   next_syncOut = eqZero;
      `TBSE_SO_COMPARE_B_VALUE:   next_syncOut = eqCmpB;
      default:         next_syncOut = 1'b0;
    endcase
  end

  // Zero and compare-B are levels that may hold over several ticks, with
  // a period of zero, say; only a fresh rise of the source sends a pulse.
  reg syncSrcLast;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      chainSyncOut <= 1'b0;
      syncSrcLast  <= 1'b0;
    end else if (timebaseClock) begin
      chainSyncOut <= next_syncOut & ~syncSrcLast;
      syncSrcLast  <= next_syncOut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags and read mux.

  // Counter events are qualified by the tick, so each counter state sets
  // its flag once however slow the divider runs.
  wire [3:0] intEvents;
  assign intEvents[`TBSE_IRQ_PRD]  = timebaseClock & eqPeriod;
  assign intEvents[`TBSE_IRQ_ZERO] = timebaseClock & eqZero;
  assign intEvents[`TBSE_IRQ_COMPARE_B_VALUE] = timebaseClock & eqCmpB;
  assign intEvents[`TBSE_IRQ_SYNC] = syncEdge;

  wire [3:0] intClear = (writeHit & (paddr == `TBSE_OFF_INTSTAT)) ?
                        pwdata[3:0] : 4'h0;

  // A new event wins over a clear in the same cycle.
  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      intStatus <= 4'h0;
    else
      intStatus <= (intStatus & ~intClear) | intEvents;
  end

  assign irq = |(intStatus & intMask);

  // Read data is taken in the setup cycle, so it stands through the whole
  // access cycle without a wait state.

  always @(posedge clock or negedge nrst) begin
    if (!nrst)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `TBSE_OFF_CTRL:    prdata <= {16'h0000, control};
        `TBSE_OFF_STATUS:  prdata <= {30'h00000000, countAtMaximum,
                                      countDirection};
        `TBSE_OFF_PHASE:   prdata <= {16'h0000, phaseValue};
        `TBSE_OFF_COUNT:   prdata <= {16'h0000, timebaseCounter};
        `TBSE_OFF_PERIOD:  prdata <= {16'h0000, periodImmediateLoad ?
                                      periodActive : periodShadow};
        `TBSE_OFF_COMPARE_B_VALUE:    prdata <= {16'h0000, compareBValue};
        `TBSE_OFF_INTSTAT: prdata <= {28'h0000000, intStatus};
        `TBSE_OFF_INTMASK: prdata <= {28'h0000000, intMask};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// *** test/tbse_timebase_props.sv ***
// Port-level assertions for the time-base block.
`timescale 1ns/1ns
module tbse_timebase_props (
  input wire        clock,           // system clock
  input wire        nrst,            // async reset, active low
  input wire        psel,            // APB select
  input wire        penable,         // APB access phase
  input wire [11:0] paddr,           // APB byte address
  input wire        pslverr,         // APB error
  input wire        chainSyncOut,    // sync pulse downstream
  input wire [15:0] timebaseCounter, // counter value
  input wire        countAtZero,     // zero flag
  input wire        countAtMaximum,  // all-ones flag
  input wire        countDirection,  // high while counting up
  input wire        timebaseClock    // time-base enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Flags trail the counter by one clock, hence the past counter value.
  AST_ZERO: assert property (
    $past(nrst) |-> countAtZero == ($past(timebaseCounter) == 16'h0000))
    else $error("Zero flag does not follow counter.");
  AST_MAX: assert property (
    $past(nrst) |-> countAtMaximum == ($past(timebaseCounter) == 16'hffff))
    else $error("Maximum flag does not follow counter.");
  AST_DIRUP: assert property (
    $past(timebaseCounter) == 16'h0000 && timebaseCounter == 16'h0001
    |-> countDirection) else $error("Direction low on upward step.");
  // A zero counter that wraps to all ones is a phase load or a down-mode reload, not a step.
  AST_DIRDN: assert property (
    $past(timebaseCounter) != 16'h0000 && timebaseCounter != 16'h0000 &&
    timebaseCounter == $past(timebaseCounter) - 16'h0001
    |-> !countDirection) else $error("Direction high on downward step.");
  AST_TICK: assert property (
    $past(nrst) && timebaseCounter != $past(timebaseCounter)
    |-> $past(timebaseClock)) else $error("Counter moved without a tick.");
  AST_SOTICK: assert property (
    $past(nrst) && $changed(chainSyncOut) |-> $past(timebaseClock))
    else $error("Sync output changed without a tick.");
  AST_SOONE: assert property (
    chainSyncOut && timebaseClock |=> !chainSyncOut)
    else $error("Sync output longer than one tick.");
  AST_SLVERR: assert property (
    psel && penable |-> pslverr == (paddr > 12'h01c || paddr[1:0] != 2'b00))
    else $error("Slave error does not match address map.");
endmodule

bind tbse_timebase tbse_timebase_props tbse_timebase_props_inst (
  .clock, .nrst, .psel, .penable, .paddr, .pslverr, .chainSyncOut,
  .timebaseCounter, .countAtZero, .countAtMaximum, .countDirection,
  .timebaseClock);

// *** test/tbse_upstream.sv ***
// Upstream chain neighbour that sends sync pulses of a chosen length.
`timescale 1ns/1ns
module tbse_upstream (
  input  wire       clock,  // system clock
  input  wire       nrst,   // async reset, active low
  input  wire       fire,   // start one pulse
  input  wire [3:0] width,  // pulse length in clocks
  output reg        syncOut // pulse to the next module
);
  reg [3:0] left;
  // A neighbour's output is registered, so pulses begin on an edge.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      left    <= 4'h0;
      syncOut <= 1'b0;
    end else begin
      if (fire)
        left <= width;
      else if (left != 4'h0)
        left <= left - 4'h1;
      syncOut <= fire || left > 4'h1;
    end
  end
endmodule

// *** test/tbse_timebase_tb.sv ***
// Self-checking bench for the time-base block.
`timescale 1ns/1ns
`include "tbse_map.vh"
module tbse_timebase_tb;
  reg         clock = 1'b0;
  reg         nrst, psel, penable, pwrite, fire;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [3:0]  width;
  wire        pready, pslverr, chainSyncIn, chainSyncOut, timebaseClock;
  wire        countAtPeriod, countAtZero, countMatchCompareB, irq;
  wire        countDirection, countAtMaximum;
  wire [31:0] prdata;
  wire [15:0] timebaseCounter;
  integer     err_total = 0, samples_checked = 0, cycles = 0;

  always #10 clock = ~clock;

  tbse_timebase tbse_timebase_inst (.clock, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .chainSyncIn, .chainSyncOut,
    .timebaseCounter, .countAtPeriod, .countAtZero, .countMatchCompareB,
    .countDirection, .countAtMaximum, .timebaseClock, .irq);
  tbse_upstream tbse_upstream_inst (.clock, .nrst, .fire, .width,
    .syncOut(chainSyncIn));

  ////////////////////////////////////////
  task end_of_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
        @(posedge clock);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task waitCount(input [15:0] v);
    integer n;
    begin
      n = 0;
      @(negedge clock);
      while (timebaseCounter !== v && n < 200) begin
        n = n + 1;
        @(negedge clock);
      end
    end
  endtask

  // Counts clocks with sync output and compare-B flag high.
  task pulses(input integer len, output integer so, output integer cb);
    integer i;
    begin
      so = 0;
      cb = 0;
      for (i = 0; i < len; i = i + 1) begin
        @(negedge clock);
        so = so + (chainSyncOut === 1'b1);
        cb = cb + (countMatchCompareB === 1'b1);
      end
    end
  endtask

  task fireSync(input [3:0] w);
    begin
      @(posedge clock);
      fire  <= 1'b1;
      width <= w;
      @(posedge clock);
      fire <= 1'b0;
    end
  endtask

  ////////////////////////////////////////
  task sReset;
    begin
      chk("direction", 1, countDirection);
      apb(1'b0, `TBSE_OFF_PERIOD, 0);
      chk("period", 32'h0000ffff, rd);
      apb(1'b0, `TBSE_OFF_CTRL, 0);
      chk("ctrl", 0, rd);
      apb(1'b0, 12'h020, 0);
      chk("unmapped", 0, rd);
    end
  endtask

  // Down first: it reaches zero from any start value.
  task sModes;
    integer m, i, v, p;
    begin
      for (m = 2; m >= 0; m = m - 1) begin
        apb(1'b1, `TBSE_OFF_CTRL, m | 32'h8);
        apb(1'b1, `TBSE_OFF_PERIOD, 32'h4);
        waitCount(0);
        p = 0;
        for (i = 1; i < 10; i = i + 1) begin
          @(negedge clock);
          v = (m == 1) ? i % 5 : (m == 2) ? (5 - i % 5) % 5 :
              (i % 8 <= 4) ? i % 8 : 8 - i % 8;
          chk("count", v, timebaseCounter);
          chk("zero", p == 0, countAtZero);
          chk("atPeriod", p == 4, countAtPeriod);
          p = v;
        end
      end
    end
  endtask

  task sShadow;
    integer i;
    begin
      apb(1'b1, `TBSE_OFF_CTRL, 32'h9);
      apb(1'b1, `TBSE_OFF_PERIOD, 32'h40);
      waitCount(8);
      apb(1'b1, `TBSE_OFF_CTRL, 32'h1);
      apb(1'b1, `TBSE_OFF_PERIOD, 32'h2);
      apb(1'b0, `TBSE_OFF_PERIOD, 0);
      chk("shadow", 2, rd);
      waitCount(16'h0040);
      chk("active", 16'h0040, timebaseCounter);
      waitCount(0);
      for (i = 1; i < 7; i = i + 1) begin
        @(negedge clock);
        chk("count", i % 3, timebaseCounter);
      end
    end
  endtask

  task sSelect;
    integer s, so, cb;
    begin
      apb(1'b1, `TBSE_OFF_COMPARE_B_VALUE, 32'h2);
      for (s = 0; s < 4; s = s + 1) begin
        apb(1'b1, `TBSE_OFF_CTRL, 32'h9 | (s << 4));
        pulses(3, so, cb);
        pulses(15, so, cb);
        chk("syncOut", (s == 1 || s == 2) ? 5 : 0, so);
        chk("compare_b_value", 5, cb);
      end
    end
  endtask

  task sSync;
    integer so, cb;
    begin
      apb(1'b1, `TBSE_OFF_PHASE, 32'hffff);
      apb(1'b1, `TBSE_OFF_INTMASK, 0);
      apb(1'b1, `TBSE_OFF_CTRL, 32'h7);
      fireSync(4'h3);
      pulses(12, so, cb);
      chk("loaded", 16'hffff, timebaseCounter);
      chk("syncOut", 1, so);
      chk("maximum", 1, countAtMaximum);
      chk("irqMasked", 0, irq);
      apb(1'b0, `TBSE_OFF_STATUS, 0);
      chk("status", 2, rd & 32'h2);
      apb(1'b0, `TBSE_OFF_INTSTAT, 0);
      chk("intstat", 8, rd & 32'h8);
      apb(1'b1, `TBSE_OFF_INTMASK, 32'h8);
      @(negedge clock);
      chk("irqOn", 1, irq);
      apb(1'b1, `TBSE_OFF_INTSTAT, 32'h8);
      @(negedge clock);
      chk("irqOff", 0, irq);
      apb(1'b1, `TBSE_OFF_PHASE, 32'h0567);
      apb(1'b1, `TBSE_OFF_CTRL, 32'h3);
      fireSync(4'h1);
      pulses(12, so, cb);
      chk("ignored", 16'hffff, timebaseCounter);
      chk("forwarded", 1, so);
      apb(1'b1, `TBSE_OFF_CTRL, 32'h37);
      fireSync(4'h1);
      pulses(12, so, cb);
      chk("phase", 16'h0567, timebaseCounter);
      chk("syncOff", 0, so);
    end
  endtask

  // Slow ticks: a sync edge between ticks is still forwarded for one tick,
  // and the counter holds each value for four clocks.
  task sDivide;
    integer i, v, so, cb;
    begin
      apb(1'b1, `TBSE_OFF_CTRL, 32'h0303);
      repeat (2) @(posedge clock);
      fireSync(4'h1);
      pulses(16, so, cb);
      chk("slowForward", 4, so);
      apb(1'b1, `TBSE_OFF_CTRL, 32'h0301);
      waitCount(1);
      for (i = 1; i < 9; i = i + 1) begin
        @(negedge clock);
        v = (i < 4) ? 1 : (i < 8) ? 2 : 0;
        chk("slowCount", v, timebaseCounter);
      end
    end
  endtask

  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      end_of_test;
    end
  end

  initial begin
    nrst    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
    fire    = 1'b0;
    width   = 4'h1;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    sReset;
    sModes;
    sShadow;
    sSelect;
    sSync;
    sDivide;
    end_of_test;
  end
endmodule
